// ### design/dsru_pkg.sv
package dsru_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned MAG_W     = 15;
  localparam int unsigned SIGN_POS  = 15;
  localparam int unsigned COUNT_W   = 6;

  // ----------------------------------------------------------------
  // Operation codes (octal 260, 264, 024)
  // ----------------------------------------------------------------
  localparam logic [8:0] OP_DIVIDE = 9'h0b0;
  localparam logic [8:0] OP_TWIN   = 9'h0b4;
  localparam logic [8:0] OP_SLR    = 9'h014;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned PULSE_NS      = 500;
  localparam int unsigned PULSE_CYC     = PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned DIV_PAUSE_NS  = 39000;
  localparam int unsigned DIV_PULSES    = DIV_PAUSE_NS / PULSE_NS;
  localparam int unsigned GROUP_PULSES  = 5;
  localparam int unsigned TRIAL_PHASE   = 1;
  localparam int unsigned DIV_TRIALS    = 16;
  localparam int unsigned SLR_BASE_NS   = 6000;
  localparam int unsigned SLR_ONE_NS    = 6500;
  localparam int unsigned SLR_TWO_NS    = 7500;
  localparam int unsigned SLR_ONE_PULSES = (SLR_ONE_NS - SLR_BASE_NS) / PULSE_NS;
  localparam int unsigned SLR_TWO_PULSES = (SLR_TWO_NS - SLR_BASE_NS) / PULSE_NS;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {S_IDLE, S_DIV, S_SLR, S_ROUND} dsru_state_type;

  // Pause length in timing pulses for a shift count
  function automatic logic [6:0] slr_pause(input logic [COUNT_W-1:0] n);
    logic [6:0] p;
    p = 7'h00;
    if (n == 6'h01)
      p = 7'(SLR_ONE_PULSES);
    else if (n == 6'h02)
      p = 7'(SLR_TWO_PULSES);
    else if (n != 6'h00)
      p = {1'b0, n} - 7'h01;
    return p;
  endfunction

endpackage

// ### design/dsru_pulse_gen.sv
`timescale 1ns/1ps

module dsru_pulse_gen #(
  parameter int unsigned CYC = dsru_pkg::PULSE_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic restart,
  output logic      tick
);

  localparam int unsigned CW = $clog2(CYC);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  logic [CW-1:0] cnt_r;

  // Free-running divider, realigned at each start
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      cnt_r <= '0;
    else if (restart || cnt_r == LAST)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 1'b1;
  end

  // One-cycle timing pulse
  assign tick = (cnt_r == LAST) && !restart;

endmodule

// ### design/dsru_unit.sv
`timescale 1ns/1ps

// Overview of operation
// - Divide leaves quotient in ext, remainder and quotient sign in acc.
// - Divide pulses group in fives, one trial subtraction and shift each.
// - A divide does sixteen trial subtractions in a 39.0 us pause.
// - Divide is octal code 260, indexable, 51.0 us including fetch.
// - Twin divide, octal 264, gives the left operand half to both elements.
// - Shift-and-round shifts acc and ext left by N, then rounds to 15 bits.
// - Each left shift moves bits up one, drops position 1, keeps the sign.
// - Shift-and-round shifts one place per timing pulse until the count.
// - After shifts: complement if negative, add ext top bit, restore sign.
// - The extension sign position is a magnitude bit and the rounding bit.
// - Shift-and-round takes 6, 6.5, 7.5 or 6.0 plus (N-1)/2 us for N >= 3.
// - Shift-and-round is octal 024, not indexed, may overflow on rounding.
// - Both elements run the same operation at once, each on its own half except in twin divide.
// - Each acc and extension is 16 bits; acc has one sign, fifteen magnitude bits.
// - Negatives are in complement form; vacated places fill with the sign.
module dsru_unit (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [8:0]  opcode,
  input  wire logic [5:0]  shift_count,
  input  wire logic [15:0] operand_left,
  input  wire logic [15:0] operand_right,
  input  wire logic        load,
  input  wire logic [15:0] load_acc_left,
  input  wire logic [15:0] load_acc_right,
  input  wire logic [15:0] load_ext_left,
  input  wire logic [15:0] load_ext_right,
  output logic             busy,
  output logic             done,
  output logic             overflow,
  output logic [15:0]      acc_left,
  output logic [15:0]      acc_right,
  output logic [15:0]      ext_left,
  output logic [15:0]      ext_right
);

  // ----------------------------------------------------------------
  // Local constants
  // ----------------------------------------------------------------
  localparam logic [6:0] DIV_END   = 7'(dsru_pkg::DIV_PULSES);
  localparam logic [2:0] GRP_LAST  = 3'(dsru_pkg::GROUP_PULSES - 1);
  localparam logic [2:0] TRIAL_PH  = 3'(dsru_pkg::TRIAL_PHASE);
  localparam logic [4:0] TRIALS    = 5'(dsru_pkg::DIV_TRIALS);
  localparam int unsigned SP       = dsru_pkg::SIGN_POS;
  localparam int unsigned MW       = dsru_pkg::MAG_W;

  dsru_pkg::dsru_state_type state_r;
  logic       tick;
  logic [6:0] pcnt_r;
  logic [2:0] phase_r;
  logic [2:0] phase_nxt;
  logic [4:0] trials_r;
  logic [5:0] nshift_r;
  logic [5:0] shifted_r;
  logic [6:0] pause_end_r;
  logic       done_r;
  logic       first;
  logic       go_div;
  logic       go_slr;
  logic       bad_op;
  logic       do_trial;
  logic       div_end;
  logic       do_shift;
  logic       slr_end;
  logic       do_round;
  logic       do_load;
  logic [1:0] ovf;

  // ----------------------------------------------------------------
  // Timing pulse source
  // ----------------------------------------------------------------
  dsru_pulse_gen #(
    .CYC     (dsru_pkg::PULSE_CYC)
  ) dsru_pulse_gen_inst (
    .clk     (clk),
    .rst     (rst),
    .restart (first),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // Decode and step strobes
  // ----------------------------------------------------------------
  assign first   = (state_r == dsru_pkg::S_IDLE) && start;
  assign go_div  = first && (opcode == dsru_pkg::OP_DIVIDE ||
                             opcode == dsru_pkg::OP_TWIN);
  assign go_slr  = first && (opcode == dsru_pkg::OP_SLR);
  assign bad_op  = first && !go_div && !go_slr;
  assign phase_nxt = (phase_r == GRP_LAST) ? 3'h0 : phase_r + 3'h1;
  // One trial per five-pulse group
  assign do_trial = (state_r == dsru_pkg::S_DIV) && tick &&
                    (phase_nxt == TRIAL_PH) && (trials_r < TRIALS);
  assign div_end  = (state_r == dsru_pkg::S_DIV) && tick &&
                    (pcnt_r + 7'h01 == DIV_END);
  // First shift on the start edge, then one per pulse
  assign do_shift = (go_slr && shift_count != 6'h00) ||
                    ((state_r == dsru_pkg::S_SLR) && tick &&
                     (shifted_r < nshift_r));
  assign slr_end  = (state_r == dsru_pkg::S_SLR) && tick &&
                    (pcnt_r + 7'h01 >= pause_end_r);
  assign do_round = (state_r == dsru_pkg::S_ROUND);
  assign do_load  = load && (state_r == dsru_pkg::S_IDLE) && !start;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= dsru_pkg::S_IDLE;
    end else begin
      case (state_r)
        dsru_pkg::S_IDLE: begin
          if (go_div)
            state_r <= dsru_pkg::S_DIV;
          else if (go_slr && dsru_pkg::slr_pause(shift_count) == 7'h00)
            state_r <= dsru_pkg::S_ROUND;
          else if (go_slr)
            state_r <= dsru_pkg::S_SLR;
        end
        dsru_pkg::S_DIV: begin
          if (div_end)
            state_r <= dsru_pkg::S_IDLE;
        end
        dsru_pkg::S_SLR: begin
          if (slr_end)
            state_r <= dsru_pkg::S_ROUND;
        end
        dsru_pkg::S_ROUND: state_r <= dsru_pkg::S_IDLE;
        default: state_r <= dsru_pkg::S_IDLE;
      endcase
    end
  end

  // Pulse, phase and step counters
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcnt_r      <= 7'h00;
      phase_r     <= 3'h0;
      trials_r    <= 5'h00;
      shifted_r   <= 6'h00;
      nshift_r    <= 6'h00;
      pause_end_r <= 7'h00;
    end else if (first) begin
      pcnt_r      <= 7'h00;
      phase_r     <= 3'h0;
      trials_r    <= 5'h00;
      shifted_r   <= (shift_count != 6'h00) ? 6'h01 : 6'h00;
      nshift_r    <= shift_count;
      pause_end_r <= dsru_pkg::slr_pause(shift_count);
    end else if (tick) begin
      pcnt_r    <= pcnt_r + 7'h01;
      phase_r   <= phase_nxt;
      trials_r  <= do_trial ? trials_r + 5'h01 : trials_r;
      shifted_r <= do_shift ? shifted_r + 6'h01 : shifted_r;
    end
  end

  // Completion strobe at divide end, after rounding, or for an unknown opcode
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      done_r <= 1'b0;
    else
      done_r <= div_end || do_round || bad_op;
  end

  assign done     = done_r;
  assign busy     = (state_r != dsru_pkg::S_IDLE);
  assign overflow = |ovf;

  // ----------------------------------------------------------------
  // Arithmetic elements, left (0) and right (1)
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : g_el
    logic [15:0] acc_r;
    logic [15:0] ext_r;
    logic [15:0] rem_r;
    logic [14:0] dsr_r;
    logic        qsign_r;
    logic        ovf_r;
    logic [15:0] opnd;
    logic [16:0] trial_in;
    logic [16:0] diff;
    logic        borrow;
    logic        neg;
    logic [14:0] mag;
    logic        rbit;
    logic [15:0] sum;

    // Twin divide sends the left half to both elements
    assign opnd = (g == 0 || opcode == dsru_pkg::OP_TWIN) ?
                  operand_left : operand_right;
    assign trial_in = {rem_r, ext_r[SP]};
    assign diff     = trial_in - {2'b00, dsr_r};
    assign borrow   = diff[16];
    // Rounding in magnitude form
    assign neg  = acc_r[SP];
    assign mag  = neg ? ~acc_r[MW-1:0] : acc_r[MW-1:0];
    assign rbit = neg ? ~ext_r[SP] : ext_r[SP];
    assign sum  = {1'b0, mag} + {15'h0000, rbit};

    // Accumulator and extension
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        acc_r <= 16'h0000;
        ext_r <= 16'h0000;
      end else if (do_load) begin
        acc_r <= (g == 0) ? load_acc_left : load_acc_right;
        ext_r <= (g == 0) ? load_ext_left : load_ext_right;
      end else if (go_div) begin
        ext_r <= neg ? ~ext_r : ext_r;
      end else if (do_trial) begin
        ext_r <= {ext_r[14:0], ~borrow};
      end else if (div_end) begin
        acc_r <= {qsign_r, qsign_r ? ~rem_r[MW-1:0] : rem_r[MW-1:0]};
        ext_r <= qsign_r ? ~ext_r : ext_r;
      end else if (do_shift) begin
        acc_r <= {acc_r[SP], acc_r[13:0], ext_r[SP]};
        ext_r <= {ext_r[14:0], acc_r[SP]};
      end else if (do_round) begin
        acc_r <= {neg, neg ? ~sum[MW-1:0] : sum[MW-1:0]};
      end
    end

    // Divide working registers
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        rem_r   <= 16'h0000;
        dsr_r   <= 15'h0000;
        qsign_r <= 1'b0;
      end else if (go_div) begin
        rem_r   <= {1'b0, mag};
        dsr_r   <= opnd[SP] ? ~opnd[MW-1:0] : opnd[MW-1:0];
        qsign_r <= acc_r[SP] ^ opnd[SP];
      end else if (do_trial) begin
        rem_r <= borrow ? trial_in[15:0] : diff[15:0];
      end
    end

    // Rounding overflow, held until the next start
    always_ff @(posedge clk or posedge rst) begin
      if (rst)
        ovf_r <= 1'b0;
      else if (first)
        ovf_r <= 1'b0;
      else if (do_round && sum[MW])
        ovf_r <= 1'b1;
    end

    assign ovf[g] = ovf_r;
  end

  // Both elements step together from one sequencer
  assign acc_left  = g_el[0].acc_r;
  assign acc_right = g_el[1].acc_r;
  assign ext_left  = g_el[0].ext_r;
  assign ext_right = g_el[1].ext_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [11:0] run_r;
  logic        was_div_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_r     <= 12'h000;
      was_div_r <= 1'b0;
    end else if (first) begin
      run_r     <= 12'h001;
      was_div_r <= go_div;
    end else if (busy) begin
      run_r     <= run_r + 12'h001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_div_time;
    (done && was_div_r) |->
      run_r == 12'(DIV_END * dsru_pkg::PULSE_CYC) + 12'h001;
  endproperty
  a_div_time: assert property (p_div_time) else $error("div time");

  property p_trials;
    div_end |-> trials_r == TRIALS;
  endproperty
  a_trials: assert property (p_trials) else $error("trial count not sixteen");

  property p_sign_keep;
    do_shift |=> g_el[0].acc_r[SP] == $past(g_el[0].acc_r[SP]);
  endproperty
  a_sign_keep: assert property (p_sign_keep) else $error("shift changed sign");

  property p_shift_move;
    do_shift |=> g_el[1].acc_r[14:1] == $past(g_el[1].acc_r[13:0]) &&
                 g_el[1].ext_r[0] == $past(g_el[1].acc_r[SP]);
  endproperty
  a_shift_move: assert property (p_shift_move) else $error("shift moved bits wrong");

  property p_round_up;
    (do_round && !g_el[0].acc_r[SP] && g_el[0].ext_r[SP] &&
     g_el[0].acc_r[MW-1:0] != 15'h7fff)
      |=> g_el[0].acc_r == $past(g_el[0].acc_r) + 16'h0001;
  endproperty
  a_round_up: assert property (p_round_up) else $error("round carry missing");

  property p_twin;
    (go_div && opcode == dsru_pkg::OP_TWIN) |=> g_el[1].dsr_r == g_el[0].dsr_r;
  endproperty
  a_twin: assert property (p_twin) else $error("twin divisor differs");

  property p_slr_time;
    (go_slr && shift_count != 6'h00) |=> busy [*8];
  endproperty
  a_slr_time: assert property (p_slr_time) else $error("slr short");

  property p_slr_done;
    (done && !was_div_r && run_r > 12'h001) |->
      run_r == 12'(pause_end_r) * 12'(dsru_pkg::PULSE_CYC) + 12'h002;
  endproperty
  a_slr_done: assert property (p_slr_done) else $error("shift-round time wrong");

  property p_bad_op;
    bad_op |=> done && !busy;
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("unknown opcode not answered");

  c_div:   cover property (div_end && g_el[1].qsign_r);
  c_twin:  cover property (go_div && opcode == dsru_pkg::OP_TWIN);
  c_ovf:   cover property (do_round && g_el[0].sum[MW]);
  c_slr5:  cover property (go_slr && shift_count == 6'h05);
endmodule

// ### verification/dsru_seq_model.sv
`timescale 1ns/1ps

// ------------------------------------------------
// Sequencing control and operand path stand-in
// ------------------------------------------------
module dsru_seq_model (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        busy,
  input  wire logic        go,
  input  wire logic [8:0]  go_op,
  input  wire logic [5:0]  go_count,
  input  wire logic [15:0] go_left,
  input  wire logic [15:0] go_right,
  output logic             start,
  output logic [8:0]       opcode,
  output logic [5:0]       shift_count,
  output logic [15:0]      operand_left,
  output logic [15:0]      operand_right
);
  logic take;

  // Request only while the datapath is free
  assign take = go && !busy && !start;

  // One-cycle start strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start <= 1'b0;
    end else begin
      start <= take;
    end
  end

  // Fields valid in the start cycle only, scrambled otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {opcode, shift_count, operand_left, operand_right} <= '0;
    end else if (take) begin
      opcode        <= go_op;
      shift_count   <= go_count;
      operand_left  <= go_left;
      operand_right <= go_right;
    end else begin
      opcode        <= ~opcode;
      shift_count   <= ~shift_count;
      operand_left  <= ~operand_left;
      operand_right <= ~operand_right;
    end
  end
endmodule

// ### verification/dsru_unit_tb.sv
`timescale 1ns/1ps

module dsru_unit_tb;
  logic        clk, rst, start, load, busy, done, overflow, go;
  logic [8:0]  opcode, go_op;
  logic [5:0]  shift_count, go_count;
  logic [15:0] operand_left, operand_right, go_left, go_right;
  logic [15:0] load_acc_left, load_acc_right, load_ext_left, load_ext_right;
  logic [15:0] acc_left, acc_right, ext_left, ext_right;
  logic [63:0] regs_all;
  int          error_cnt, comparisons, cyc;
  int          div_cyc;

  // ------------------------------------------------
  // Device and partner
  // ------------------------------------------------
  dsru_unit dsru_unit_inst (
    .clk, .rst, .start, .opcode, .shift_count, .operand_left,
    .operand_right, .load, .load_acc_left, .load_acc_right,
    .load_ext_left, .load_ext_right, .busy, .done, .overflow,
    .acc_left, .acc_right, .ext_left, .ext_right
  );
  dsru_seq_model dsru_seq_model_inst (
    .clk, .rst, .busy, .go, .go_op, .go_count, .go_left, .go_right,
    .start, .opcode, .shift_count, .operand_left, .operand_right
  );

  // Register view and divide length
  assign regs_all = {acc_left, ext_left, acc_right, ext_right};
  assign div_cyc  = int'(dsru_pkg::DIV_PULSES * dsru_pkg::PULSE_CYC);

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Load both elements and read back
  task automatic preload(input logic [63:0] v);
    @(posedge clk);
    load <= 1'b1;
    {load_acc_left, load_ext_left, load_acc_right, load_ext_right} <= v;
    @(posedge clk);
    load <= 1'b0;
    #1;
    check(regs_all, v);
  endtask

  // Issue one operation, count cycles from start edge to done
  task automatic run_op(input logic [8:0] op, input logic [5:0] n,
                        input logic [15:0] l, input logic [15:0] r);
    @(posedge clk);
    go <= 1'b1;
    {go_op, go_count, go_left, go_right} <= {op, n, l, r};
    {load_acc_left, load_ext_right} <= ~{load_acc_left, load_ext_right};
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    cyc = 0;
    while (done !== 1'b1 && cyc < 3000) begin
      @(posedge clk);
      load <= (cyc == 3);
      #1;
      cyc++;
    end
    if (cyc >= 3000) begin
      error_cnt++;
      complete_run();
    end
    check(busy, 1'b0);
  endtask

  // Expected shift-and-round result: {overflow, acc, ext}
  function automatic logic [32:0] slr_ref(input logic [15:0] a,
                                          input logic [15:0] e,
                                          input logic [5:0]  n);
    logic        s;
    logic [30:0] m;
    logic [15:0] sum;
    s = a[15];
    m = s ? ~{a[14:0], e} : {a[14:0], e};
    m = m << n;
    sum = {1'b0, m[30:16]} + {15'h0000, m[15]};
    return {sum[15], s, s ? ~sum[14:0] : sum[14:0], s ? ~m[15:0] : m[15:0]};
  endfunction

  function automatic int slr_cyc(input logic [5:0] n);
    int p;
    p = (n == 0) ? 0 : (n == 1) ? 1 : (n == 2) ? 3 : int'(n) - 1;
    return int'(dsru_pkg::PULSE_CYC) * p + 1;
  endfunction

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task automatic test_divide;
    preload(64'h1000_0000_0800_0000);
    run_op(dsru_pkg::OP_DIVIDE, 6'h00, 16'h3000, 16'h4000);
    check(cyc, div_cyc);
    check({acc_left, ext_left}, 32'h1000_5555);
    check({acc_right, ext_right}, 32'h0000_2000);
    $display("divide test done");
  endtask

  task automatic test_twin;
    preload(64'hefff_ffff_0800_0000);
    run_op(dsru_pkg::OP_TWIN, 6'h00, 16'h3000, 16'h7fff);
    check(cyc, div_cyc);
    check({acc_left, ext_left}, 32'hefff_aaaa);
    check({acc_right, ext_right}, 32'h2000_2aaa);
    $display("twin divide test done");
  endtask

  task automatic test_slr;
    logic [15:0] tv [5][4];
    logic [5:0]  tn [5];
    logic [32:0] el, er;
    tv = '{'{16'h7fff, 16'h8000, 16'h8123, 16'h4567},
           '{16'h1234, 16'hc000, 16'hf00f, 16'h1234},
           '{16'h0abc, 16'h5555, 16'hc3c3, 16'haaaa},
           '{16'h0001, 16'hffff, 16'h8000, 16'h0001},
           '{16'h0000, 16'h0007, 16'hfffe, 16'hfff0}};
    tn = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h14};
    for (int i = 0; i < 5; i++) begin
      preload({tv[i][0], tv[i][1], tv[i][2], tv[i][3]});
      el = slr_ref(tv[i][0], tv[i][1], tn[i]);
      er = slr_ref(tv[i][2], tv[i][3], tn[i]);
      run_op(dsru_pkg::OP_SLR, tn[i], 16'h5a5a, 16'ha5a5);
      check(cyc, slr_cyc(tn[i]));
      check(overflow, el[32] | er[32]);
      check(acc_left, el[31:16]);
      check(ext_left, el[15:0]);
      check(acc_right, er[31:16]);
      check(ext_right, er[15:0]);
    end
    $display("shift and round test done");
  endtask

  task automatic test_misc;
    preload(64'h1111_2222_3333_4444);
    run_op(9'h0aa, 6'h05, 16'h0001, 16'h0002);
    check(cyc, 0);
    check(regs_all, 64'h1111_2222_3333_4444);
    @(posedge clk);
    go <= 1'b1;
    {go_op, go_count} <= {dsru_pkg::OP_SLR, 6'h3f};
    @(posedge clk);
    go <= 1'b0;
    repeat (30) @(posedge clk);
    #1;
    check(busy, 1'b1);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    #1;
    check(regs_all, 64'h0);
    check({busy, done, overflow}, 3'h0);
    @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check({busy, done}, 2'h0);
    $display("decode and reset test done");
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    rst = 1'b1;
    {load, go, go_op, go_count, go_left, go_right} = '0;
    {load_acc_left, load_acc_right, load_ext_left, load_ext_right} = '0;
    error_cnt = 0;
    comparisons = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(regs_all, 64'h0);
    check({busy, done, overflow}, 3'h0);
    test_divide();
    test_twin();
    test_slr();
    test_misc();
    complete_run();
  end
endmodule
